// ---- common/io_line_pkg.sv ----
// constants, register map and types of the i/o line and sleep block
package io_line_pkg;
    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int MS_PS         = 1000000000;
    localparam int MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
    localparam int SLEEP_UNIT_MS = 10;
    // line configuration
    localparam int N_LINES_DEF   = 8;
    localparam int CODE_W        = 4;
    localparam logic [3:0] CODE_DISABLED = 4'h0;
    localparam logic [3:0] CODE_PERIPH   = 4'h1;
    localparam logic [3:0] CODE_ANALOG   = 4'h2;
    localparam logic [3:0] CODE_MONITOR  = 4'h3;
    localparam logic [3:0] CODE_OUT_LOW  = 4'h4;
    localparam logic [3:0] CODE_OUT_HIGH = 4'h5;
    localparam logic [3:0] CODE_XCVR_LOW = 4'h6;
    localparam logic [3:0] CODE_XCVR_HI  = 4'h7;
    localparam int CODE_BAD_BIT = 3;
    // sleep settings
    localparam logic [2:0]  MODE_CYCLIC     = 3'h4;
    localparam logic [2:0]  MODE_CYCLIC_PIN = 3'h5;
    localparam int          OPT_FULL_WAKE   = 1;
    localparam int          OPT_EXTENDED    = 2;
    localparam logic [15:0] IR_SINGLE       = 16'h0800;
    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_SLEEP_MODE  = 8'h00;
    localparam logic [7:0] REG_SLEEP_OPT   = 8'h04;
    localparam logic [7:0] REG_SLEEP_PER   = 8'h08;
    localparam logic [7:0] REG_SLEEP_CNT   = 8'h0C;
    localparam logic [7:0] REG_WAKE_TIME   = 8'h10;
    localparam logic [7:0] REG_SAMPLE_INT  = 8'h14;
    localparam logic [7:0] REG_PULL_EN     = 8'h18;
    localparam logic [7:0] REG_PULL_DIR    = 8'h1C;
    localparam logic [7:0] REG_CFG_PEND    = 8'h20;
    localparam logic [7:0] REG_COMMAND     = 8'h24;
    localparam logic [7:0] REG_STATUS      = 8'h28;
    localparam logic [7:0] REG_CFG_ACTIVE  = 8'h2C;
    localparam logic [7:0] REG_SAMPLE      = 8'h30;
    localparam int CMD_APPLY = 0;
    localparam int CMD_SLEEP = 1;
    localparam int STAT_AWAKE = 0;
    localparam int STAT_ERR   = 1;
    // reset values and bus response codes
    localparam logic [15:0] SLEEP_PER_RST  = 16'h0020;
    localparam logic [15:0] SLEEP_CNT_RST  = 16'h0001;
    localparam logic [15:0] WAKE_TIME_RST  = 16'h1388;
    localparam logic [15:0] SAMPLE_INT_RST = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        S_AWAKE = 2'b01,
        S_ASLEEP = 2'b10
    } sleep_state_e;
endpackage

// ---- rtl/tick_div.sv ----
// enable divider: one-cycle tick every DIV enabled cycles
`timescale 1ns/10ps
module tick_div
    import io_line_pkg::*;
#(
    parameter int DIV = 10
)
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // enable in, tick out
    input  wire logic en,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt  <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (en)
            begin
                if (cnt == CW'(DIV - 1))
                begin
                    cnt  <= '0;
                    tick <= 1'b1;
                end
                else
                    cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// ---- rtl/io_line_ctrl.sv ----
// i/o line configuration, pulls and cyclic sleep driven sampling
//
// How it works
// R1: sleep period counts 10 ms steps; wake timer and interval count 1 ms.
// R2: mode 4 is timed cyclic sleep; mode 5 also obeys the request pin.
// R3: while awake, a sample every interval until the wake timer ends.
// R4: samples only when some line is analog or monitored digital input.
// R5: extended sleep option stays asleep period times count.
// R6: option 0x06 adds the full wake timer after an extended sleep.
// R7: interval 0x800 gives one sample right after waking.
// R8: sleep-now command sleeps at once, wake timer or not.
// R9: codes 0..5 decode to disabled, peripheral, analog, monitor, out lo/hi.
// R10: code 6 low-active, 7 high-active transceiver enable; above 7 invalid.
// R11: codes 0 and 3 act alike as inputs; only 3 is sampled.
// R12: line configuration written stays pending until applied.
// R13: pull enable bit set pulls an input line, clear leaves it floating.
// R14: pull direction bit set pulls up, clear pulls down, if enabled.
// R15: write with an invalid code is refused, kept old, flagged as error.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module io_line_ctrl
    import io_line_pkg::*;
#(
    parameter int N_LINES = N_LINES_DEF,
    parameter int MS_DIV  = MS_CYCLES
)
(
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0]  awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    // axi4-lite write response
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]  araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // i/o lines
    input  wire logic [N_LINES-1:0] line_in,
    output logic [N_LINES-1:0]      line_out,
    output logic [N_LINES-1:0]      line_oe,
    output logic [N_LINES-1:0]      pull_up_en,
    output logic [N_LINES-1:0]      pull_down_en,
    output logic [N_LINES-1:0]      periph_sel,
    output logic [N_LINES-1:0]      analog_sel,
    // transceiver and sleep pins
    input  wire logic               xcvr_active,
    input  wire logic               sleep_request_pin,
    output logic                    awake,
    // sample output
    output logic                    sample_strobe,
    output logic [N_LINES-1:0]      sample_digital,
    output logic [N_LINES-1:0]      sample_dmask,
    output logic [N_LINES-1:0]      sample_amask
);
    localparam int CFG_W = N_LINES * CODE_W;

    logic [2:0]         sleep_mode_select;
    logic [7:0]         sleep_options;
    logic [15:0]        sleep_period_setting;
    logic [15:0]        sleep_count_setting;
    logic [15:0]        wake_time_setting;
    logic [15:0]        sample_interval_setting;
    logic [N_LINES-1:0] pull_enable_mask;
    logic [N_LINES-1:0] pull_direction_mask;
    logic [CFG_W-1:0]   cfg_pend;
    logic [CFG_W-1:0]   cfg_act;
    logic               cfg_err;

    logic               aw_held;
    logic               w_held;
    logic [ADDR_W-1:0]  aw_addr;
    logic [31:0]        w_data;
    logic               do_write;
    logic               cfg_bad;
    logic               apply_cmd;
    logic               sleep_cmd;

    logic               ms_tick;
    logic               sp_tick;
    sleep_state_e       state;
    logic [15:0]        wake_ms;
    logic [15:0]        ir_ms;
    logic [15:0]        per_cnt;
    logic [15:0]        sn_cnt;
    logic               just_woke;
    logic               cyclic;
    logic               extended;
    logic [15:0]        wake_limit;
    logic               go_sleep;
    logic               go_wake;
    logic               sample_fire;
    logic [N_LINES-1:0] dmask;
    logic [N_LINES-1:0] amask;

    ////////////////////////////////////////////////////////////////////////
    // time bases

    tick_div #(.DIV(MS_DIV)) u_ms_div
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en      (1'b1),
        .tick    (ms_tick)
    );

    tick_div #(.DIV(SLEEP_UNIT_MS)) u_sp_div
    (
        .aclk    (aclk),
        .aresetn (aresetn && !awake), // R1
        .en      (ms_tick),
        .tick    (sp_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write side

    assign do_write  = aw_held && w_held && !bvalid;
    assign apply_cmd = do_write && aw_addr == REG_COMMAND
                       && w_data[CMD_APPLY];
    assign sleep_cmd = do_write && aw_addr == REG_COMMAND
                       && w_data[CMD_SLEEP];

    always_comb
    begin
        cfg_bad = 1'b0;
        for (int i = 0; i < N_LINES; i++)
            if (w_data[i*CODE_W + CODE_BAD_BIT])
                cfg_bad = 1'b1; // R10
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end
        else
        begin
            awready <= !aw_held && !awready && !bvalid;
            wready  <= !w_held && !wready && !bvalid;
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= {awaddr[ADDR_W-1:2], 2'b00};
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data <= wdata;
                wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (aw_addr == REG_CFG_PEND && cfg_bad)
                           ? RESP_SLVERR : RESP_OKAY; // R15
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // settings registers; full words, wstrb ignored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sleep_mode_select       <= '0;
            sleep_options           <= '0;
            sleep_period_setting    <= SLEEP_PER_RST;
            sleep_count_setting     <= SLEEP_CNT_RST;
            wake_time_setting       <= WAKE_TIME_RST;
            sample_interval_setting <= SAMPLE_INT_RST;
            pull_enable_mask        <= '0;
            pull_direction_mask     <= '0;
        end
        else if (do_write)
        begin
            unique case (aw_addr)
                REG_SLEEP_MODE: sleep_mode_select       <= w_data[2:0];
                REG_SLEEP_OPT:  sleep_options           <= w_data[7:0];
                REG_SLEEP_PER:  sleep_period_setting    <= w_data[15:0];
                REG_SLEEP_CNT:  sleep_count_setting     <= w_data[15:0];
                REG_WAKE_TIME:  wake_time_setting       <= w_data[15:0];
                REG_SAMPLE_INT: sample_interval_setting <= w_data[15:0];
                REG_PULL_EN:    pull_enable_mask    <= w_data[N_LINES-1:0];
                REG_PULL_DIR:   pull_direction_mask <= w_data[N_LINES-1:0];
                default: ;
            endcase
        end
    end

    // pending and active line configuration
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_pend <= '0;
            cfg_act  <= '0;
        end
        else
        begin
            if (do_write && aw_addr == REG_CFG_PEND && !cfg_bad)
                cfg_pend <= w_data[CFG_W-1:0]; // R12 R15
            if (apply_cmd)
                cfg_act <= cfg_pend; // R12
        end
    end

    // sticky error; a refusal beats a same-cycle clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_err <= 1'b0;
        else if (do_write && aw_addr == REG_CFG_PEND && cfg_bad)
            cfg_err <= 1'b1; // R15
        else if (do_write && aw_addr == REG_STATUS && w_data[STAT_ERR])
            cfg_err <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read side

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end
        else
        begin
            arready <= !arready && !rvalid;
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= RESP_OKAY;
                rdata   <= '0;
                unique case ({araddr[ADDR_W-1:2], 2'b00})
                    REG_SLEEP_MODE: rdata[2:0]  <= sleep_mode_select;
                    REG_SLEEP_OPT:  rdata[7:0]  <= sleep_options;
                    REG_SLEEP_PER:  rdata[15:0] <= sleep_period_setting;
                    REG_SLEEP_CNT:  rdata[15:0] <= sleep_count_setting;
                    REG_WAKE_TIME:  rdata[15:0] <= wake_time_setting;
                    REG_SAMPLE_INT: rdata[15:0] <= sample_interval_setting;
                    REG_PULL_EN:    rdata[N_LINES-1:0] <= pull_enable_mask;
                    REG_PULL_DIR:   rdata[N_LINES-1:0] <= pull_direction_mask;
                    REG_CFG_PEND:   rdata[CFG_W-1:0] <= cfg_pend;
                    REG_COMMAND:    rdata <= '0;
                    REG_STATUS:
                    begin
                        rdata[STAT_AWAKE] <= state == S_AWAKE;
                        rdata[STAT_ERR]   <= cfg_err;
                    end
                    REG_CFG_ACTIVE: rdata[CFG_W-1:0] <= cfg_act;
                    REG_SAMPLE:     rdata[N_LINES-1:0] <= sample_digital;
                    default:        rresp <= RESP_SLVERR;
                endcase
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-line pin decode

    for (genvar g = 0; g < N_LINES; g++)
    begin : g_line
        logic [3:0] code;
        logic       is_in;

        assign code     = cfg_act[g*CODE_W +: CODE_W];
        assign is_in    = code == CODE_DISABLED || code == CODE_MONITOR; // R11
        assign dmask[g] = code == CODE_MONITOR; // R11
        assign amask[g] = code == CODE_ANALOG;

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                line_out[g]     <= 1'b0;
                line_oe[g]      <= 1'b0;
                periph_sel[g]   <= 1'b0;
                analog_sel[g]   <= 1'b0;
                pull_up_en[g]   <= 1'b0;
                pull_down_en[g] <= 1'b0;
            end
            else
            begin
                periph_sel[g] <= code == CODE_PERIPH; // R9
                analog_sel[g] <= code == CODE_ANALOG; // R9
                line_oe[g]    <= code == CODE_OUT_LOW
                                 || code == CODE_OUT_HIGH
                                 || code == CODE_XCVR_LOW
                                 || code == CODE_XCVR_HI; // R9 R10
                line_out[g]   <= code == CODE_OUT_HIGH
                                 || (code == CODE_XCVR_LOW && !xcvr_active)
                                 || (code == CODE_XCVR_HI && xcvr_active);
                pull_up_en[g]   <= is_in && pull_enable_mask[g]
                                   && pull_direction_mask[g]; // R13 R14
                pull_down_en[g] <= is_in && pull_enable_mask[g]
                                   && !pull_direction_mask[g]; // R13 R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cyclic sleep

    assign cyclic   = sleep_mode_select == MODE_CYCLIC
                      || sleep_mode_select == MODE_CYCLIC_PIN; // R2
    assign extended = sleep_options[OPT_EXTENDED]; // R5

    // extended sleep wakes for 1 ms unless full wake is set
    always_comb
    begin
        if (extended && !sleep_options[OPT_FULL_WAKE])
            wake_limit = 16'h0001;
        else if (wake_time_setting == '0)
            wake_limit = 16'h0001;
        else
            wake_limit = wake_time_setting; // R6
    end

    assign go_sleep = state == S_AWAKE && cyclic
        && ((ms_tick && wake_ms + 16'h0001 >= wake_limit) // R3
            || sleep_cmd // R8
            || (sleep_mode_select == MODE_CYCLIC_PIN
                && sleep_request_pin)); // R2

    assign go_wake = state == S_ASLEEP
        && (!cyclic
            || (sleep_mode_select == MODE_CYCLIC_PIN && !sleep_request_pin)
            || (sp_tick && per_cnt + 16'h0001 >= sleep_period_setting
                && (!extended
                    || sn_cnt + 16'h0001 >= sleep_count_setting))); // R1 R5

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state     <= S_AWAKE;
            just_woke <= 1'b0;
        end
        else
        begin
            just_woke <= go_wake;
            if (go_sleep)
                state <= S_ASLEEP;
            else if (go_wake)
                state <= S_AWAKE;
        end
    end

    // sleep period and count counters
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state == S_AWAKE)
        begin
            per_cnt <= '0;
            sn_cnt  <= '0;
        end
        else if (sp_tick)
        begin
            if (per_cnt + 16'h0001 >= sleep_period_setting)
            begin
                per_cnt <= '0;
                sn_cnt  <= sn_cnt + 16'h0001; // R5
            end
            else
                per_cnt <= per_cnt + 16'h0001; // R1
        end
    end

    // wake timer and sample interval, both in ms
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state == S_ASLEEP)
        begin
            wake_ms <= '0;
            ir_ms   <= '0;
        end
        else if (ms_tick)
        begin
            wake_ms <= wake_ms + 16'h0001; // R1
            if (ir_ms + 16'h0001 >= sample_interval_setting)
                ir_ms <= '0;
            else
                ir_ms <= ir_ms + 16'h0001; // R1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sampling

    assign sample_fire = state == S_AWAKE && (|(dmask | amask)) // R4
        && (sample_interval_setting == IR_SINGLE
            ? just_woke // R7
            : (ms_tick && sample_interval_setting != '0
               && ir_ms + 16'h0001 >= sample_interval_setting)); // R3

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sample_strobe  <= 1'b0;
            sample_digital <= '0;
            sample_dmask   <= '0;
            sample_amask   <= '0;
            awake          <= 1'b1;
        end
        else
        begin
            awake         <= state == S_AWAKE;
            sample_strobe <= sample_fire;
            if (sample_fire)
            begin
                sample_digital <= line_in & dmask; // R11
                sample_dmask   <= dmask;
                sample_amask   <= amask;
            end
        end
    end
endmodule

// ---- verif/io_line_ctrl_chk.sv ----
// port assertions of the i/o line block
`timescale 1ns/10ps
module io_line_ctrl_chk
    import io_line_pkg::*;
#(
    parameter int N = N_LINES_DEF
)
(
    // clock and reset
    input logic         aclk,
    input logic         aresetn,
    // bus answers
    input logic         bvalid,
    input logic         bready,
    input logic [1:0]   bresp,
    input logic         rvalid,
    input logic         rready,
    input logic [31:0]  rdata,
    // lines
    input logic [N-1:0] line_out,
    input logic [N-1:0] line_oe,
    input logic [N-1:0] pull_up_en,
    input logic [N-1:0] pull_down_en,
    input logic [N-1:0] periph_sel,
    input logic [N-1:0] analog_sel,
    // sampling
    input logic         awake,
    input logic         sample_strobe,
    input logic [N-1:0] sample_digital,
    input logic [N-1:0] sample_dmask,
    input logic [N-1:0] sample_amask
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
chk_pull_excl: assert property ((pull_up_en & pull_down_en) == '0)
    else $error("both pulls on");
chk_pull_inputs: assert property (((pull_up_en | pull_down_en)
    & (line_oe | periph_sel | analog_sel)) == '0) else $error("pull on");
chk_func_excl: assert property (~|(line_oe & (periph_sel | analog_sel))
    && ~|(periph_sel & analog_sel)) else $error("two functions");
chk_out_drive: assert property ((line_out & ~line_oe) == '0)
    else $error("undriven high");
chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe long");
chk_sample_src: assert property (sample_strobe |->
    (sample_dmask | sample_amask) != '0) else $error("empty sample");
chk_sample_mon: assert property (sample_strobe |->
    (sample_digital & ~sample_dmask) == '0) else $error("unmonitored bit");
chk_sample_hold: assert property ($changed(sample_digital)
    |-> sample_strobe) else $error("sample moved");
chk_bresp_hold: assert property (bvalid & !bready |=> bvalid & $stable(bresp))
    else $error("bresp dropped");
chk_rdata_hold: assert property (rvalid & !rready |=> rvalid & $stable(rdata))
    else $error("rdata dropped");
cov_sample: cover property (sample_strobe);
cov_asleep: cover property ($fell(awake));
cov_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule

bind io_line_ctrl io_line_ctrl_chk #(.N(N_LINES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .line_out(line_out), .line_oe(line_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .periph_sel(periph_sel),
    .analog_sel(analog_sel), .awake(awake), .sample_strobe(sample_strobe),
    .sample_digital(sample_digital), .sample_dmask(sample_dmask),
    .sample_amask(sample_amask));

// ---- verif/line_partner.sv ----
// far-side circuit of the i/o lines
`timescale 1ns/10ps
module line_partner
#(
    parameter int N = 8
)
(
    input  logic         aclk,
    // block's drive and pulls
    input  logic [N-1:0] line_out,
    input  logic [N-1:0] line_oe,
    input  logic [N-1:0] pull_up_en,
    input  logic [N-1:0] pull_down_en,
    // resolved line level
    output logic [N-1:0] line_in
);
logic [N-1:0] flt = '0;
// floating lines toggle
always_ff @(posedge aclk) flt <= ~flt;
assign line_in = (line_oe & line_out)
    | (~line_oe & (pull_up_en | (~pull_down_en & flt)));
endmodule

// ---- verif/tb_io_line_ctrl.sv ----
// testbench of the i/o line and sleep block
`timescale 1ns/10ps
module tb_io_line_ctrl;
import io_line_pkg::*;
localparam int MSD = 4;
logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
logic arvalid = 0, rready = 0, xcvr_active = 0, sleep_request_pin = 0;
logic [7:0] awaddr = '0, araddr = '0, line_in, line_out, line_oe;
logic [7:0] pull_up_en, pull_down_en, periph_sel, analog_sel, e, d;
logic [7:0] sample_digital, sample_dmask, sample_amask;
logic [31:0] wdata = '0, rdata;
logic [1:0] bresp, rresp;
logic awready, wready, bvalid, arready, rvalid, awake, sample_strobe;
int n_errors = 0, checked = 0, sl, aw, ns;
logic [31:0] tb [4][7] = '{
    '{0, 1, 2, 32'h76543210, 80, 7 * MSD, 3},
    '{4, 3, 32'h800, 32'h76543210, 240, MSD, 1},
    '{6, 3, 32'h800, 32'h76543210, 240, 7 * MSD, 1},
    '{0, 1, 2, 32'h11111111, 80, 7 * MSD, 0}};
always #12.5 aclk = ~aclk;
io_line_ctrl #(.N_LINES(8), .MS_DIV(MSD)) DUT (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .periph_sel(periph_sel),
    .analog_sel(analog_sel), .xcvr_active(xcvr_active),
    .sleep_request_pin(sleep_request_pin), .awake(awake),
    .sample_strobe(sample_strobe), .sample_digital(sample_digital),
    .sample_dmask(sample_dmask), .sample_amask(sample_amask));
line_partner #(.N(8)) u_far (.aclk(aclk), .line_out(line_out),
    .line_oe(line_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .line_in(line_in));
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
        n_errors++;
        $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
endtask
task automatic end_of_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] v,
                  input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 0;
        if (wvalid && wready) wvalid <= 0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 0;
    check(32'(bresp), 32'(er));
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] x,
                  input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    check(rdata, x);
    check(32'(rresp), 32'(er));
endtask
// one sleep and wake, in cycles
task automatic meas(output int s, output int w, output int n);
    s = 0; w = 0; n = 0;
    @(posedge aclk);
    while (awake) @(posedge aclk);
    while (!awake) begin s++; @(posedge aclk); end
    while (awake) begin n += int'(sample_strobe); w++; @(posedge aclk); end
endtask
task automatic wait_lvl(input logic v);
    for (int k = 0; k < 20 && awake !== v; k++)
        @(posedge aclk);
    check(32'(awake), 32'(v));
endtask
////////////////////////////////////////////////////////////////////////
always @(posedge aclk)
    if (aresetn && sample_strobe === 1'b1)
    begin
        check(32'(sample_dmask), 32'h08);
        check(32'(sample_amask), 32'h04);
        check(32'(sample_digital), 32'h08);
    end
initial
begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    end_of_test;
end
initial
begin
    void'($urandom(94315));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    xcvr_active <= 1'($urandom);
    rd(REG_SLEEP_PER, 32'h20, RESP_OKAY);
    rd(REG_WAKE_TIME, 32'h1388, RESP_OKAY);
    rd(REG_STATUS, 32'h1, RESP_OKAY);
    rd(8'hFC, 0, RESP_SLVERR);
    wr(REG_CFG_PEND, 32'h76543210, RESP_OKAY);
    rd(REG_CFG_ACTIVE, 0, RESP_OKAY);
    check(32'(line_oe), 0);
    wr(REG_COMMAND, 1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(line_oe), 32'hF0);
    check(32'(line_out), {xcvr_active, ~xcvr_active, 6'h20});
    check(32'({periph_sel, analog_sel}), 32'h0204);
    wr(REG_CFG_PEND, 32'h00000080, RESP_SLVERR);
    rd(REG_CFG_PEND, 32'h76543210, RESP_OKAY);
    rd(REG_STATUS, 32'h3, RESP_OKAY);
    wr(REG_STATUS, 2, RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
        e = (i == 4) ? 8'h08 : 8'($urandom);
        d = (i == 4) ? 8'h08 : 8'($urandom);
        wr(REG_PULL_EN, 32'(e), RESP_OKAY);
        wr(REG_PULL_DIR, 32'(d), RESP_OKAY);
        repeat (2) @(posedge aclk);
        check(32'(pull_up_en), 32'(e & d & 8'h09));
        check(32'(pull_down_en), 32'(e & ~d & 8'h09));
    end
    wr(REG_SLEEP_PER, 2, RESP_OKAY);
    wr(REG_WAKE_TIME, 7, RESP_OKAY);
    wr(REG_SLEEP_MODE, 32'(MODE_CYCLIC), RESP_OKAY);
    foreach (tb[r])
    begin
        wr(REG_SLEEP_OPT, tb[r][0], RESP_OKAY);
        wr(REG_SLEEP_CNT, tb[r][1], RESP_OKAY);
        wr(REG_SAMPLE_INT, tb[r][2], RESP_OKAY);
        wr(REG_CFG_PEND, tb[r][3], RESP_OKAY);
        wr(REG_COMMAND, 1, RESP_OKAY);
        meas(sl, aw, ns);
        meas(sl, aw, ns);
        check(32'(sl >= tb[r][4] - 2 && sl <= tb[r][4] + 2), 1);
        check(32'(aw >= tb[r][5] - 2 && aw <= tb[r][5] + 2), 1);
        check(32'(ns), tb[r][6]);
    end
    wr(REG_SLEEP_MODE, 32'(MODE_CYCLIC_PIN), RESP_OKAY);
    wr(REG_WAKE_TIME, 32'h1388, RESP_OKAY);
    wait_lvl(1'b1);
    sleep_request_pin <= 1;
    wait_lvl(1'b0);
    sleep_request_pin <= 0;
    wait_lvl(1'b1);
    wr(REG_SLEEP_MODE, 32'(MODE_CYCLIC), RESP_OKAY);
    wait_lvl(1'b1);
    wr(REG_COMMAND, 2, RESP_OKAY);
    wait_lvl(1'b0);
    end_of_test;
end
endmodule
